// ==== hdl/ccdb_map.vh ====
`ifndef CCDB_MAP_VH
`define CCDB_MAP_VH
// How it works
// R1 - cycle-class pin is low for control cycles and high for data cycles
// R2 - halt, interrupt service and code fetch cycles are control cycles
// R3 - operand transfers to memory or I/O space are data cycles
// R4 - cycle-class pin has a three-state driver that can be released
// R5 - thirty-two bidirectional three-state data lines carry all transfers
// R6 - reads and interrupt acknowledge: drivers off, lines sampled
// R7 - memory and I/O writes: drivers on, write data presented
// R8 - hold-acknowledge or float state floats every data line
// R9 - narrow bus request: only low sixteen lines used, wide access split
// R10 - cycle-class pin floats under the same hold and float conditions

// cycle type codes on i_cyc_type
`define CCDB_CYC_IDLE   4'h0
`define CCDB_CYC_HALT   4'h1
`define CCDB_CYC_INTA   4'h2
`define CCDB_CYC_FETCH  4'h3
`define CCDB_CYC_MEMRD  4'h4
`define CCDB_CYC_MEMWR  4'h5
`define CCDB_CYC_IORD   4'h6
`define CCDB_CYC_IOWR   4'h7
`define CCDB_CYC_SHUT   4'h8

// sequencer states
`define CCDB_ST_IDLE    2'h0
`define CCDB_ST_LOW     2'h1
`define CCDB_ST_HIGH    2'h2

// reset value and narrow bus half width
`define CCDB_RST_DATA   32'h0000_0000
`define CCDB_HALF_W     16
`endif

// ==== hdl/ccdb_class.v ====
`include "ccdb_map.vh"
module ccdb_class (
  // cycle type in
  input  wire [3:0] i_cyc_type,
  // decoded attributes
  output reg        o_is_data,
  output reg        o_is_write,
  output reg        o_is_read,
  output reg        o_valid
);
  always @* begin
    o_is_data  = 1'b0;
    o_is_write = 1'b0;
    o_is_read  = 1'b0;
    o_valid    = 1'b1;
    case (i_cyc_type)
      `CCDB_CYC_HALT,
      `CCDB_CYC_SHUT:  o_is_write = 1'b1; // R2
      `CCDB_CYC_INTA:  o_is_read  = 1'b1; // R2
      `CCDB_CYC_FETCH: o_is_read  = 1'b1; // R2
      `CCDB_CYC_MEMRD,
      `CCDB_CYC_IORD: begin
        o_is_data = 1'b1; // R3
        o_is_read = 1'b1;
      end
      `CCDB_CYC_MEMWR,
      `CCDB_CYC_IOWR: begin
        o_is_data  = 1'b1; // R3
        o_is_write = 1'b1;
      end
      default: o_valid = 1'b0;
    endcase
  end
endmodule

// ==== hdl/ccdb_top.v ====
`include "ccdb_map.vh"
module ccdb_top #(
  parameter DATA_W = 32
) (
  // clock and reset
  input  wire              i_ref_clk,
  input  wire              i_rstn,
  // core side cycle request
  input  wire              i_cyc_start,
  input  wire [3:0]        i_cyc_type,
  input  wire [DATA_W-1:0] i_wr_data,
  input  wire              i_hold_ack,
  input  wire              i_float,
  // external pins
  input  wire              i_narrow_bus_request_n,
  input  wire              i_bus_ready_n,
  input  wire [DATA_W-1:0] i_data_lines,
  output reg  [DATA_W-1:0] o_data_lines,
  output reg  [DATA_W-1:0] o_data_lines_oe,
  output reg               o_dc,
  output reg               o_dc_oe,
  // core side results
  output reg  [DATA_W-1:0] o_rd_data,
  output reg               o_rd_valid,
  output reg               o_cyc_done,
  output reg               o_busy
);
  localparam HALF = `CCDB_HALF_W;

  // two-flop synchronisers for pin inputs; stage one read only by stage two
  reg [DATA_W-1:0] data_s1;
  reg [DATA_W-1:0] data_s2;
  reg              nbr_s1;
  reg              nbr_s2;
  reg              rdy_s1;
  reg              rdy_s2;
  always @(posedge i_ref_clk) begin
    if (!i_rstn) begin
      data_s1 <= `CCDB_RST_DATA;
      data_s2 <= `CCDB_RST_DATA;
      nbr_s1  <= 1'b1;
      nbr_s2  <= 1'b1;
      rdy_s1  <= 1'b1;
      rdy_s2  <= 1'b1;
    end else begin
      data_s1 <= i_data_lines; // R6
      data_s2 <= data_s1;
      nbr_s1  <= i_narrow_bus_request_n;
      nbr_s2  <= nbr_s1;
      rdy_s1  <= i_bus_ready_n;
      rdy_s2  <= rdy_s1;
    end
  end

  wire is_data;
  wire is_write;
  wire is_read;
  wire valid;
  ccdb_class u_class (
    .i_cyc_type (i_cyc_type),
    .o_is_data  (is_data),
    .o_is_write (is_write),
    .o_is_read  (is_read),
    .o_valid    (valid)
  );

  // float condition is a plain level from the arbitration logic
  wire released = i_hold_ack | i_float;

  reg [1:0]        state;
  reg [1:0]        next_state;
  reg              cur_data;
  reg              cur_write;
  reg              cur_narrow;
  reg [DATA_W-1:0] wr_buf;
  reg [HALF-1:0]   low_half;

  always @* begin
    next_state = state;
    case (state)
      `CCDB_ST_IDLE:
        if (i_cyc_start && valid && !released)
          next_state = `CCDB_ST_LOW;
      `CCDB_ST_LOW:
        if (!rdy_s2) begin
          // narrow bus only carries half a word per cycle
          if (cur_narrow)
            next_state = `CCDB_ST_HIGH; // R9
          else
            next_state = `CCDB_ST_IDLE;
        end
      `CCDB_ST_HIGH:
        if (!rdy_s2)
          next_state = `CCDB_ST_IDLE;
      default: next_state = `CCDB_ST_IDLE;
    endcase
  end

  always @(posedge i_ref_clk) begin
    if (!i_rstn) begin
      state           <= `CCDB_ST_IDLE;
      cur_data        <= 1'b0;
      cur_write       <= 1'b0;
      cur_narrow      <= 1'b0;
      wr_buf          <= `CCDB_RST_DATA;
      low_half        <= {HALF{1'b0}};
      o_data_lines    <= `CCDB_RST_DATA;
      o_data_lines_oe <= {DATA_W{1'b0}};
      o_dc            <= 1'b0;
      o_dc_oe         <= 1'b0;
      o_rd_data       <= `CCDB_RST_DATA;
      o_rd_valid      <= 1'b0;
      o_cyc_done      <= 1'b0;
      o_busy          <= 1'b0;
    end else begin
      state      <= next_state;
      o_rd_valid <= 1'b0;
      o_cyc_done <= 1'b0;
      o_busy     <= (next_state != `CCDB_ST_IDLE);
      if (state == `CCDB_ST_IDLE && next_state == `CCDB_ST_LOW) begin
        cur_data   <= is_data;
        cur_write  <= is_write;
        // narrow request is sampled at the cycle's start
        cur_narrow <= !nbr_s2; // R9
        wr_buf     <= i_wr_data;
      end
      if (state == `CCDB_ST_LOW && !rdy_s2) begin
        if (cur_narrow)
          low_half <= data_s2[HALF-1:0]; // R9
        else if (!cur_write) begin
          o_rd_data  <= data_s2; // R6
          o_rd_valid <= 1'b1;
        end
      end
      if (state == `CCDB_ST_HIGH && !rdy_s2 && !cur_write) begin
        // upper half arrives on the low lines
        o_rd_data  <= {data_s2[HALF-1:0], low_half}; // R9
        o_rd_valid <= 1'b1;
      end
      if (state != `CCDB_ST_IDLE && next_state == `CCDB_ST_IDLE)
        o_cyc_done <= 1'b1;

      // pin drive from the next state so pins track the sequencer
      if (released) begin
        o_data_lines_oe <= {DATA_W{1'b0}}; // R8
        o_dc_oe         <= 1'b0; // R10
      end else begin
        o_dc_oe <= 1'b1; // R4
        if (state == `CCDB_ST_IDLE && next_state == `CCDB_ST_LOW) begin
          o_dc <= is_data; // R1
          o_data_lines_oe <= {DATA_W{is_write}}; // R7
          o_data_lines    <= i_wr_data; // R5
        end else if (next_state == `CCDB_ST_HIGH) begin
          o_dc <= cur_data; // R1
          o_data_lines_oe <= {DATA_W{cur_write}}; // R7
          o_data_lines <= {wr_buf[DATA_W-1:HALF],
                           wr_buf[DATA_W-1:HALF]}; // R9
        end else if (next_state == `CCDB_ST_IDLE) begin
          o_data_lines_oe <= {DATA_W{1'b0}}; // R6
        end
      end
    end
  end
endmodule

// ==== verif/ccdb_monitor.sv ====
module ccdb_monitor #(parameter DATA_W = 32) (
  // clock and reset
  input wire logic              i_ref_clk,
  input wire logic              i_rstn,
  // core side request
  input wire logic              i_cyc_start,
  input wire logic [3:0]        i_cyc_type,
  input wire logic [DATA_W-1:0] i_wr_data,
  input wire logic              i_hold_ack,
  input wire logic              i_float,
  // pins and status
  input wire logic [DATA_W-1:0] o_data_lines,
  input wire logic [DATA_W-1:0] o_data_lines_oe,
  input wire logic              o_dc,
  input wire logic              o_dc_oe,
  input wire logic              o_busy,
  input wire logic              o_cyc_done
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_rstn);
  logic [15:0] wd;
  always @(posedge i_ref_clk) wd <= i_wr_data[15:0];
  wire rel = i_hold_ack | i_float;
  wire tk = !o_busy & i_cyc_start & !rel & i_cyc_type inside {[1:8]};
  property p_ctl; tk & i_cyc_type inside {1,2,3,8} |=> !o_dc; endproperty
  a_ctl: assert property (p_ctl) else $error("class");
  property p_dat; tk & i_cyc_type inside {[4:7]} |=> o_dc; endproperty
  a_dat: assert property (p_dat) else $error("class");
  property p_dcf; rel |=> !o_dc_oe; endproperty
  a_dcf: assert property (p_dcf) else $error("class float");
  property p_dcon; !rel |=> o_dc_oe; endproperty
  a_dcon: assert property (p_dcon) else $error("class drive");
  property p_dfl; rel |=> o_data_lines_oe == 0; endproperty
  a_dfl: assert property (p_dfl) else $error("data float");
  property p_rd;
    tk & i_cyc_type inside {2,3,4,6} |=> (o_data_lines_oe == 0) [*4];
  endproperty
  a_rd: assert property (p_rd) else $error("read drive");
  property p_wr;
    tk & i_cyc_type inside {5,7} |=>
      &o_data_lines_oe[15:0] && o_data_lines[15:0] == wd;
  endproperty
  a_wr: assert property (p_wr) else $error("write data");
  property p_end; o_cyc_done |-> !o_busy && o_data_lines_oe == 0; endproperty
  a_end: assert property (p_end) else $error("end drive");
  c_rd: cover property (tk & i_cyc_type == 4'h4);
  c_wr: cover property (tk & i_cyc_type == 4'h5);
  c_ref: cover property (rel & i_cyc_start);
endmodule
bind ccdb_top ccdb_monitor #(.DATA_W(DATA_W)) i_mon (.*);

// ==== verif/ccdb_partner.sv ====
module ccdb_partner (
  input  wire logic        clk,
  input  wire logic        busy,
  input  wire logic        oe,
  input  wire logic [3:0]  dly,
  input  wire logic [31:0] rdv,
  output logic             rdy_n = 1,
  output logic [31:0]      dq = 0
);
  timeunit 1ns;
  timeprecision 1ps;
  int n = 0;
  // gap after a ready pulse so the synced pin is not counted twice
  always @(posedge clk) begin
    rdy_n <= 1;
    dq <= busy & !oe ? rdv : ~dq;
    n <= busy ? n + 1 : 0;
    if (busy && n == dly) begin
      rdy_n <= 0;
      n <= -5;
    end
  end
endmodule

// ==== verif/test_cpu_cycle_class_and_data_bus.sv ====
module test_cpu_cycle_class_and_data_bus;
  timeunit 1ns;
  timeprecision 1ps;
  logic        i_ref_clk = 0, i_rstn = 0, i_cyc_start = 0, i_bus_ready_n;
  logic        i_hold_ack = 0, i_float = 0, i_narrow_bus_request_n = 1;
  logic [3:0]  i_cyc_type = 0, dly = 0;
  logic [31:0] i_wr_data = 0, rdv = 0, dq, o_data_lines, o_data_lines_oe;
  logic [31:0] o_rd_data;
  logic        o_dc, o_dc_oe, o_rd_valid, o_cyc_done, o_busy;
  wire  [31:0] i_data_lines = o_data_lines_oe & o_data_lines
                            | ~o_data_lines_oe & dq;
  logic [33:0] q[$], e;
  int          n_mismatch = 0, comparisons = 0, seed = 93676, j;
  ccdb_top i_ccdb_top (.*);
  ccdb_partner i_ccdb_partner (.clk(i_ref_clk), .busy(o_busy), .dly(dly),
    .oe(o_data_lines_oe[0]), .rdv(rdv), .rdy_n(i_bus_ready_n), .dq(dq));
  initial forever #4 i_ref_clk = ~i_ref_clk;
  task chk(input logic [31:0] s, x);
    comparisons++;
    if (s !== x) begin
      n_mismatch++;
      $display("BAD %0t got %h want %h", $time, s, x);
    end
  endtask
  task results;
    if (n_mismatch == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // start held two edges: the second one is a refused start while busy
  task go(input logic [3:0] t, input logic nb, pu);
    logic [31:0] r;
    r = $random(seed);
    @(posedge i_ref_clk);
    i_narrow_bus_request_n <= !nb;
    rdv <= r;
    dly <= $random(seed) & 7;
    repeat (3) @(posedge i_ref_clk);
    if (pu) q.push_back({t inside {2,3,4,6}, t inside {[4:7]},
                         nb ? {r[15:0], r[15:0]} : r});
    i_cyc_start <= 1;
    i_cyc_type <= t;
    i_wr_data <= $random(seed);
    repeat (2) @(posedge i_ref_clk);
    i_cyc_start <= 0;
    for (j = 0; pu && o_cyc_done !== 1 && j < 99; j++) @(negedge i_ref_clk);
    if (j == 99) chk(0, 1);
  endtask
  always @(posedge i_ref_clk) if (o_cyc_done === 1) begin
    if (q.size() == 0) chk(1, 0);
    else begin
      e = q.pop_front();
      chk(o_dc, e[32]);
      chk(o_rd_valid, e[33]);
      if (e[33]) chk(o_rd_data, e[31:0]);
    end
  end
  initial begin
    repeat (10) @(posedge i_ref_clk);
    i_rstn <= 1;
    for (int k = 0; k < 40; k++) go(k % 8 + 1, $random(seed), 1);
    @(posedge i_ref_clk) i_hold_ack <= 1;
    go(5, 0, 0);
    @(posedge i_ref_clk) i_hold_ack <= 0;
    go(0, 0, 0);
    go(9, 0, 0);
    @(negedge i_ref_clk);
    chk(o_busy, 0);
    chk(q.size(), 0);
    results;
  end
  initial begin
    #100000;
    n_mismatch++;
    results;
  end
endmodule
